/* File: verilog/pmbsf_status_bank.sv */
// Purpose: Current, input, temperature and other_error_flag_a/logic fault status.
// Assumes: Command decoder on the same clock presents read/write
//          strokes; analog detector levels arrive asynchronously.
// Notes:   Latched flags clear by clear-all or write-one; set wins.
// Function
// - Current bit 5 latches overcurrent warning until cleared.
// - Current bit 4 latches undercurrent fault until cleared.
// - Current bits 6 and 3:0 always read zero.
// - Clear-all or write-one clears flags, other bits unchanged.
// - Input bit 7 latches input overvoltage fault.
// - Input bit 6 latches input overvoltage warning.
// - Input bit 5 latches input undervoltage warning.
// - Input bit 3 is live: one while power input is off or the 5V rail is not ok.
// - Live off bit is one after reset and never raises alert.
// - Undervoltage warning alert masked until input first turns on.
// - Input bits 4 and 2:0 always read zero.
// - Temperature bit 7 latches overtemperature fault.
// - Temperature bit 6 latches overtemperature warning; 5:0 read zero.
// - Other_error_flag_a bit 7 latches on unsupported command code.
// - Other_error_flag_a bit 6 latches on invalid or unsupported data.
// - Other_error_flag_a bit 5 latches on packet error check failure.
// - Other_error_flag_a bit 4 latches memory error, bit 3 logic core error.
// - Other_error_flag_a bit 1 latches other other_error_flag_a errors; bits 2, 0 read zero.
// - Follower reports back-channel failure as other_error_flag_a fault.
// - Summary bit is OR of other_error_flag_a flags, tracking sets and clears.
// - Each alert-capable bit has a mask bit suppressing its alert.
`timescale 1ns/1ps
module pmbsf_status_bank
   import pmbsf_pkg::*;
(
   // Clock and reset
   input  wire logic            core_clk_in,
   input  wire logic            rst_in,
   // Command port from host decoder
   input  wire logic            cmd_read_in,
   input  wire logic            cmd_write_in,
   input  wire logic [7:0]      cmd_code_in,
   input  wire logic [7:0]      cmd_wdata_in,
   input  wire logic            clear_faults_in,
   output logic      [7:0]      rd_data_out,
   output logic                 rd_valid_out,
   // Asynchronous detector levels
   input  wire pmbsf_det_t      detect_in,
   // Same-clock other_error_flag_a/logic events
   input  wire pmbsf_other_error_flag_a_evt_t other_error_flag_a_evt_in,
   input  wire logic            follower_mode_in,
   // Alert masks
   input  wire pmbsf_mask_t     alert_mask_in,
   // Status outputs
   output logic                 alert_out,
   output logic                 other_error_flag_a_summary_out
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   pmbsf_det_t  det;
   logic [7:0]  current_reg;
   logic [7:0]  current_next;
   logic [7:0]  input_reg;
   logic [7:0]  input_next;
   logic [7:0]  temp_reg;
   logic [7:0]  temp_next;
   logic [7:0]  other_error_flag_a_reg;
   logic [7:0]  other_error_flag_a_next;
   logic [7:0]  current_set;
   logic [7:0]  input_set;
   logic [7:0]  temp_set;
   logic [7:0]  other_error_flag_a_set;
   logic        input_off;
   logic        uvw_armed_reg;
   logic [7:0]  rd_data_reg;
   logic        rd_valid_reg;
   logic        alert_reg;
   logic        alert_next;
   logic [7:0]  input_view;
   logic [7:0]  input_alert_bits;

   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic [7:0] clear_bits(
      input logic [7:0] code,
      input logic [7:0] target
   );
      logic [7:0] bits;
      bits = clear_faults_in ? ALL_ONES : STATUS_RESET;
      if (cmd_write_in && (code == target)) begin
         bits = bits | cmd_wdata_in;
      end
      return bits;
   endfunction

   function automatic logic [7:0] update_flags(
      input logic [7:0] cur,
      input logic [7:0] set,
      input logic [7:0] clr,
      input logic [7:0] sup
   );
      return ((cur & ~clr) | set) & sup;
   endfunction

   // ***********************************************************
   // Detector synchroniser
   // ***********************************************************
   pmbsf_sync_filter u_sync (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .raw_in      (detect_in),
      .level_out   (det)
   );

   // ***********************************************************
   // Set terms
   // ***********************************************************
   always_comb begin
      current_set                = STATUS_RESET;
      current_set[OC_FAULT_BIT]  = det.oc_fault;
      current_set[OC_WARN_BIT]   = det.oc_warn;
      current_set[UC_FAULT_BIT]  = det.uc_fault;
      input_set                  = STATUS_RESET;
      input_set[INPUT_OVERVOLTAGE_FAULT_FLAG_BIT]     = det.vin_ov_fault;
      input_set[INPUT_OVERVOLTAGE_WARN_FLAG_BIT]     = det.vin_ov_warn;
      input_set[INPUT_UNDERVOLTAGE_WARN_FLAG_BIT]     = det.vin_uv_warn;
      temp_set                   = STATUS_RESET;
      temp_set[OT_FAULT_BIT]     = det.ot_fault;
      temp_set[OT_WARN_BIT]      = det.ot_warn;
      other_error_flag_a_set                   = STATUS_RESET;
      other_error_flag_a_set[BAD_CMD_BIT]      = other_error_flag_a_evt_in.bad_command;
      other_error_flag_a_set[BAD_DATA_BIT]     = other_error_flag_a_evt_in.bad_data;
      other_error_flag_a_set[PEC_FAIL_BIT]     = other_error_flag_a_evt_in.pec_fail;
      other_error_flag_a_set[MEM_ERR_BIT]      = other_error_flag_a_evt_in.mem_error;
      other_error_flag_a_set[CORE_ERR_BIT]     = other_error_flag_a_evt_in.core_error;
      other_error_flag_a_set[OTHER_ERR_BIT]    = other_error_flag_a_evt_in.other_error
                                 | (follower_mode_in
                                    & other_error_flag_a_evt_in.backchannel_fail);
   end

   // ***********************************************************
   // Next flag values, set wins over clear
   // ***********************************************************
   always_comb begin
      current_next = update_flags(current_reg, current_set,
                        clear_bits(cmd_code_in, CMD_CURRENT_STATUS),
                        CURRENT_SUPPORTED);
      input_next   = update_flags(input_reg, input_set,
                        clear_bits(cmd_code_in, CMD_INPUT_STATUS),
                        INPUT_LATCHED);
      temp_next    = update_flags(temp_reg, temp_set,
                        clear_bits(cmd_code_in, CMD_TEMP_STATUS),
                        TEMP_SUPPORTED);
      other_error_flag_a_next    = update_flags(other_error_flag_a_reg, other_error_flag_a_set,
                        clear_bits(cmd_code_in, CMD_OTHER_ERROR_FLAG_A_STATUS),
                        OTHER_ERROR_FLAG_A_SUPPORTED);
   end

   // ***********************************************************
   // Latched status registers
   // ***********************************************************
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         current_reg <= STATUS_RESET;
      end else begin
         current_reg <= current_next;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         input_reg <= STATUS_RESET;
      end else begin
         input_reg <= input_next;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         temp_reg <= STATUS_RESET;
      end else begin
         temp_reg <= temp_next;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         other_error_flag_a_reg <= STATUS_RESET;
      end else begin
         other_error_flag_a_reg <= other_error_flag_a_next;
      end
   end

   // ***********************************************************
   // Live input-off indicator and undervoltage arming
   // ***********************************************************
   // Filter resets low, so the indicator reads one out of reset
   assign input_off = ~(det.input_on & det.rail_5v_ok);

   always_comb begin
      input_view                = input_reg;
      input_view[INPUT_OFF_BIT] = input_off;
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         uvw_armed_reg <= 1'b0;
      end else if (det.input_on) begin
         uvw_armed_reg <= 1'b1;
      end
   end

   // ***********************************************************
   // Read path
   // ***********************************************************
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_reg  <= STATUS_RESET;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= 1'b0;
         if (cmd_read_in) begin
            unique case (cmd_code_in)
               CMD_CURRENT_STATUS: begin
                  rd_data_reg  <= current_reg;
                  rd_valid_reg <= 1'b1;
               end
               CMD_INPUT_STATUS: begin
                  rd_data_reg  <= input_view;
                  rd_valid_reg <= 1'b1;
               end
               CMD_TEMP_STATUS: begin
                  rd_data_reg  <= temp_reg;
                  rd_valid_reg <= 1'b1;
               end
               CMD_OTHER_ERROR_FLAG_A_STATUS: begin
                  rd_data_reg  <= other_error_flag_a_reg;
                  rd_valid_reg <= 1'b1;
               end
               default: begin
                  rd_data_reg  <= STATUS_RESET;
               end
            endcase
         end
      end
   end

   assign rd_data_out  = rd_data_reg;
   assign rd_valid_out = rd_valid_reg;

   // ***********************************************************
   // Alert and summary
   // ***********************************************************
   always_comb begin
      input_alert_bits = input_reg;
      if (!uvw_armed_reg) begin
         input_alert_bits[INPUT_UNDERVOLTAGE_WARN_FLAG_BIT] = 1'b0;
      end
      alert_next = |(current_reg & ~alert_mask_in.current_mask)
                 | |(input_alert_bits & ~alert_mask_in.input_mask)
                 | |(temp_reg & ~alert_mask_in.temp_mask)
                 | |(other_error_flag_a_reg & ~alert_mask_in.other_error_flag_a_mask);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= alert_next;
      end
   end

   assign alert_out        = alert_reg;
   assign other_error_flag_a_summary_out = |other_error_flag_a_reg;

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   chk_oc_fault_latch: assert property (
      det.oc_fault |=> current_reg[OC_FAULT_BIT])
      else $error("overcurrent fault not latched");

   chk_current_hold: assert property (
      current_reg[OC_WARN_BIT] && !clear_faults_in && !cmd_write_in
      |=> current_reg[OC_WARN_BIT])
      else $error("overcurrent warning dropped without clear");

   chk_unsupported_zero: assert property (
      (current_reg & ~CURRENT_SUPPORTED) == STATUS_RESET
      && (input_view & 8'h17) == STATUS_RESET
      && (temp_reg & ~TEMP_SUPPORTED) == STATUS_RESET
      && (other_error_flag_a_reg & ~OTHER_ERROR_FLAG_A_SUPPORTED) == STATUS_RESET)
      else $error("unsupported status bit reads one");

   chk_clear_all: assert property (
      clear_faults_in && !det.ot_fault && !det.ot_warn
      |=> temp_reg == STATUS_RESET)
      else $error("clear-all left temperature flags set");

   chk_write_one: assert property (
      cmd_write_in && cmd_code_in == CMD_OTHER_ERROR_FLAG_A_STATUS && !clear_faults_in
      && other_error_flag_a_evt_in == '0
      |=> other_error_flag_a_reg == ($past(other_error_flag_a_reg) & ~$past(cmd_wdata_in)))
      else $error("write-one clear wrong on other_error_flag_a register");

   chk_live_off: assert property (
      rd_valid_out && $past(cmd_code_in) == CMD_INPUT_STATUS
      |-> rd_data_out[INPUT_OFF_BIT] == $past(input_off))
      else $error("live input-off bit misreported");

   chk_uvw_unarmed: assert property (
      !uvw_armed_reg && current_reg == STATUS_RESET
      && temp_reg == STATUS_RESET && other_error_flag_a_reg == STATUS_RESET
      && (input_reg & ~8'h20) == STATUS_RESET
      |=> !alert_out)
      else $error("alert raised by unarmed undervoltage warning");

   chk_other_error_flag_a_summary: assert property (
      cmd_write_in && cmd_code_in == CMD_OTHER_ERROR_FLAG_A_STATUS && other_error_flag_a_evt_in == '0
      && (other_error_flag_a_reg & ~cmd_wdata_in) == STATUS_RESET
      |=> !other_error_flag_a_summary_out)
      else $error("summary bit stuck after other_error_flag_a clear");

   chk_mask_blocks: assert property (
      alert_mask_in == '1 |=> !alert_out)
      else $error("alert raised with all bits masked");

   chk_backchannel: assert property (
      follower_mode_in && other_error_flag_a_evt_in.backchannel_fail
      |=> other_error_flag_a_reg[OTHER_ERR_BIT] && other_error_flag_a_summary_out)
      else $error("back-channel failure not reported");

endmodule

/* File: pkg/pmbsf_pkg.sv */
// Purpose: Shared constants and carriers for the fault status bank.
// Assumes: Byte-wide status registers reached by command code.
// Notes:   Supported-bit masks define which bits can ever latch; the live input-off bit lies outside them.
package pmbsf_pkg;

   // ***********************************************************
   // Command codes
   // ***********************************************************
   localparam logic [7:0] CMD_CURRENT_STATUS = 8'h7B;
   localparam logic [7:0] CMD_INPUT_STATUS   = 8'h7C;
   localparam logic [7:0] CMD_TEMP_STATUS    = 8'h7D;
   localparam logic [7:0] CMD_OTHER_ERROR_FLAG_A_STATUS    = 8'h7E;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int OC_FAULT_BIT    = 7;
   localparam int OC_WARN_BIT     = 5;
   localparam int UC_FAULT_BIT    = 4;
   localparam int INPUT_OVERVOLTAGE_FAULT_FLAG_BIT     = 7;
   localparam int INPUT_OVERVOLTAGE_WARN_FLAG_BIT     = 6;
   localparam int INPUT_UNDERVOLTAGE_WARN_FLAG_BIT     = 5;
   localparam int INPUT_OFF_BIT   = 3;
   localparam int OT_FAULT_BIT    = 7;
   localparam int OT_WARN_BIT     = 6;
   localparam int BAD_CMD_BIT     = 7;
   localparam int BAD_DATA_BIT    = 6;
   localparam int PEC_FAIL_BIT    = 5;
   localparam int MEM_ERR_BIT     = 4;
   localparam int CORE_ERR_BIT    = 3;
   localparam int OTHER_ERR_BIT   = 1;

   // ***********************************************************
   // Supported bits and reset values
   // ***********************************************************
   localparam logic [7:0] CURRENT_SUPPORTED = 8'hB0;
   localparam logic [7:0] INPUT_LATCHED     = 8'hE0;
   localparam logic [7:0] TEMP_SUPPORTED    = 8'hC0;
   localparam logic [7:0] OTHER_ERROR_FLAG_A_SUPPORTED    = 8'hFA;
   localparam logic [7:0] STATUS_RESET      = 8'h00;
   localparam logic [7:0] ALL_ONES          = 8'hFF;

   // ***********************************************************
   // Synchroniser
   // ***********************************************************
   localparam int DET_WIDTH = 10;

   // ***********************************************************
   // Carriers
   // ***********************************************************
   typedef struct packed {
      logic oc_fault;
      logic oc_warn;
      logic uc_fault;
      logic vin_ov_fault;
      logic vin_ov_warn;
      logic vin_uv_warn;
      logic ot_fault;
      logic ot_warn;
      logic input_on;
      logic rail_5v_ok;
   } pmbsf_det_t;

   typedef struct packed {
      logic bad_command;
      logic bad_data;
      logic pec_fail;
      logic mem_error;
      logic core_error;
      logic other_error;
      logic backchannel_fail;
   } pmbsf_other_error_flag_a_evt_t;

   typedef struct packed {
      logic [7:0] current_mask;
      logic [7:0] input_mask;
      logic [7:0] temp_mask;
      logic [7:0] other_error_flag_a_mask;
   } pmbsf_mask_t;

endpackage

/* File: verilog/pmbsf_sync_filter.sv */
// Purpose: Three-stage synchroniser with agreement filter per bit.
// Assumes: Inputs are slow levels from analog detectors.
// Notes:   Output changes only when stages two and three agree.
`timescale 1ns/1ps
module pmbsf_sync_filter
   import pmbsf_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_in,
   // Raw and filtered levels
   input  wire logic [DET_WIDTH-1:0] raw_in,
   output logic      [DET_WIDTH-1:0] level_out
);

   logic [DET_WIDTH-1:0] stage1_reg;
   logic [DET_WIDTH-1:0] stage2_reg;
   logic [DET_WIDTH-1:0] stage3_reg;
   logic [DET_WIDTH-1:0] level_reg;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end else begin
         stage1_reg <= raw_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < DET_WIDTH; i++) begin : g_filter
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
               level_reg[i] <= 1'b0;
            end else if (stage2_reg[i] == stage3_reg[i]) begin
               level_reg[i] <= stage3_reg[i];
            end
         end
      end
   endgenerate

   assign level_out = level_reg;

endmodule

/* File: testbench/pmbsf_host_model.sv */
// Purpose: Host side of the status bank command port.
// Assumes: Strokes are taken on the rising edge after they are driven.
// Notes:   Released code and data show the inverse of the last value.
`timescale 1ns/1ps
module pmbsf_host_model
   import pmbsf_pkg::*;
(
   // Clock
   input  wire logic       core_clk_in,
   // Command strokes
   output logic            cmd_read_out,
   output logic            cmd_write_out,
   output logic [7:0]      cmd_code_out,
   output logic [7:0]      cmd_wdata_out,
   output logic            clear_faults_out,
   // Read answer
   input  wire logic [7:0] rd_data_in,
   input  wire logic       rd_valid_in
);
   initial begin
      cmd_read_out     = 1'b0;
      cmd_write_out    = 1'b0;
      cmd_code_out     = 8'h00;
      cmd_wdata_out    = 8'h00;
      clear_faults_out = 1'b0;
   end

   task automatic read_reg(input logic [7:0] code,
                           output logic [7:0] data, output logic valid);
      @(posedge core_clk_in);
      #1;
      cmd_read_out = 1'b1;
      cmd_code_out = code;
      @(posedge core_clk_in);
      #1;
      valid        = rd_valid_in;
      data         = rd_data_in;
      cmd_read_out = 1'b0;
      cmd_code_out = ~code;
   endtask

   // Write-one clears only the bits given
   task automatic write_reg(input logic [7:0] code, input logic [7:0] d);
      @(posedge core_clk_in);
      #1;
      cmd_write_out = 1'b1;
      cmd_code_out  = code;
      cmd_wdata_out = d;
      @(posedge core_clk_in);
      #1;
      cmd_write_out = 1'b0;
      cmd_code_out  = ~code;
      cmd_wdata_out = ~d;
   endtask

   task automatic clear_all();
      @(posedge core_clk_in);
      #1;
      clear_faults_out = 1'b1;
      @(posedge core_clk_in);
      #1;
      clear_faults_out = 1'b0;
   endtask
endmodule

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the fault status bank.
// Assumes: Host model drives the command port; bench drives detectors.
// Notes:   Detector waits cover the three-stage filter latency.
`timescale 1ns/1ps
module testbench
   import pmbsf_pkg::*;
;
   logic            clk;
   logic            rst;
   logic            rd, wr, clr;
   logic [7:0]      code, wdata, rdata;
   logic            rvalid, alert, summary, follower;
   pmbsf_det_t      det;
   pmbsf_other_error_flag_a_evt_t evt;
   pmbsf_mask_t     mask;
   int              n_fail, n_tests, cycles;
   logic [7:0]      d;
   logic            v;
   logic [7:0]      exp_tab [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};

   pmbsf_status_bank pmbsf_status_bank_inst (
      .core_clk_in(clk), .rst_in(rst), .cmd_read_in(rd),
      .cmd_write_in(wr), .cmd_code_in(code), .cmd_wdata_in(wdata),
      .clear_faults_in(clr), .rd_data_out(rdata), .rd_valid_out(rvalid),
      .detect_in(det), .other_error_flag_a_evt_in(evt), .follower_mode_in(follower),
      .alert_mask_in(mask), .alert_out(alert), .other_error_flag_a_summary_out(summary));

   pmbsf_host_model pmbsf_host_model_inst (
      .core_clk_in(clk), .cmd_read_out(rd), .cmd_write_out(wr),
      .cmd_code_out(code), .cmd_wdata_out(wdata),
      .clear_faults_out(clr), .rd_data_in(rdata), .rd_valid_in(rvalid));

   always #25 clk = ~clk;

   // ***********************************************************
   // Helpers
   // ***********************************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
      pmbsf_host_model_inst.read_reg(c, d, v);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         complete_run();
      end
   end

   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic reset_values();
      rd_chk(CMD_CURRENT_STATUS, 8'h00);
      rd_chk(CMD_INPUT_STATUS, 8'h08);
      rd_chk(CMD_TEMP_STATUS, 8'h00);
      rd_chk(CMD_OTHER_ERROR_FLAG_A_STATUS, 8'h00);
      pmbsf_host_model_inst.read_reg(8'h7F, d, v);
      check({7'h00, v}, 8'h00);
      check(d, 8'h00);
   endtask

   task automatic uv_before_on();
      det.vin_uv_warn = 1'b1;
      tick(8);
      det.vin_uv_warn = 1'b0;
      tick(8);
      rd_chk(CMD_INPUT_STATUS, 8'h28);
      check({7'h00, alert}, 8'h00);
      pmbsf_host_model_inst.clear_all();
      rd_chk(CMD_INPUT_STATUS, 8'h08);
      det.input_on   = 1'b1;
      det.rail_5v_ok = 1'b1;
      tick(8);
      rd_chk(CMD_INPUT_STATUS, 8'h00);
      det.vin_uv_warn = 1'b1;
      tick(8);
      det.vin_uv_warn = 1'b0;
      tick(8);
      check({7'h00, alert}, 8'h01);
      det.vin_ov_fault = 1'b1;
      det.vin_ov_warn  = 1'b1;
      det.rail_5v_ok   = 1'b0;
      tick(8);
      det.vin_ov_fault = 1'b0;
      det.vin_ov_warn  = 1'b0;
      rd_chk(CMD_INPUT_STATUS, 8'hE8);
      det.rail_5v_ok = 1'b1;
      tick(8);
      pmbsf_host_model_inst.clear_all();
      rd_chk(CMD_INPUT_STATUS, 8'h00);
   endtask

   task automatic current_flags();
      det.oc_fault = 1'b1;
      det.oc_warn  = 1'b1;
      det.uc_fault = 1'b1;
      tick(8);
      det.oc_fault = 1'b0;
      det.oc_warn  = 1'b0;
      det.uc_fault = 1'b0;
      tick(8);
      rd_chk(CMD_CURRENT_STATUS, 8'hB0);
      check({7'h00, alert}, 8'h01);
      mask.current_mask = 8'hFF;
      tick(3);
      check({7'h00, alert}, 8'h00);
      mask.current_mask = 8'h00;
      pmbsf_host_model_inst.write_reg(CMD_CURRENT_STATUS, 8'h80);
      rd_chk(CMD_CURRENT_STATUS, 8'h30);
      pmbsf_host_model_inst.write_reg(CMD_CURRENT_STATUS, 8'h4F);
      rd_chk(CMD_CURRENT_STATUS, 8'h30);
      pmbsf_host_model_inst.clear_all();
      rd_chk(CMD_CURRENT_STATUS, 8'h00);
   endtask

   task automatic temp_flags();
      det.ot_fault = 1'b1;
      det.ot_warn  = 1'b1;
      tick(8);
      det.ot_fault = 1'b0;
      det.ot_warn  = 1'b0;
      tick(8);
      rd_chk(CMD_TEMP_STATUS, 8'hC0);
      pmbsf_host_model_inst.write_reg(CMD_TEMP_STATUS, 8'h7F);
      rd_chk(CMD_TEMP_STATUS, 8'h80);
      det.ot_fault = 1'b1;
      tick(8);
      pmbsf_host_model_inst.clear_all();
      rd_chk(CMD_TEMP_STATUS, 8'h80);
      det.ot_fault = 1'b0;
      tick(8);
      pmbsf_host_model_inst.clear_all();
      rd_chk(CMD_TEMP_STATUS, 8'h00);
   endtask

   task automatic other_error_flag_a_flags();
      for (int k = 0; k < 6; k++) begin
         evt = 7'h40 >> k;
         tick(1);
         evt = '0;
         check({7'h00, summary}, 8'h01);
         rd_chk(CMD_OTHER_ERROR_FLAG_A_STATUS, exp_tab[k]);
         pmbsf_host_model_inst.write_reg(CMD_OTHER_ERROR_FLAG_A_STATUS, exp_tab[k]);
         check({7'h00, summary}, 8'h00);
      end
      evt = 7'h01;
      tick(1);
      evt = '0;
      rd_chk(CMD_OTHER_ERROR_FLAG_A_STATUS, 8'h00);
      follower = 1'b1;
      evt = 7'h01;
      tick(1);
      evt = '0;
      rd_chk(CMD_OTHER_ERROR_FLAG_A_STATUS, 8'h02);
      pmbsf_host_model_inst.clear_all();
      check({7'h00, summary}, 8'h00);
      evt = 7'h40;
      tick(2);
      evt = '0;
      check({7'h00, alert}, 8'h01);
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      check({7'h00, alert}, 8'h00);
      check({7'h00, summary}, 8'h00);
      rd_chk(CMD_OTHER_ERROR_FLAG_A_STATUS, 8'h00);
   endtask

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      clk      = 1'b0;
      rst      = 1'b1;
      det      = '0;
      evt      = '0;
      mask     = '0;
      follower = 1'b0;
      n_fail   = 0;
      n_tests  = 0;
      cycles   = 0;
      tick(5);
      rst = 1'b0;
      reset_values();
      uv_before_on();
      current_flags();
      temp_flags();
      other_error_flag_a_flags();
      complete_run();
   end
endmodule
